// >>> core/usbep_defines.svh
// Register indices, bit positions and reset values of the OUT endpoint block
`ifndef USBEP_DEFINES_SVH
`define USBEP_DEFINES_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define USBEP_IDX_IN_CTRL_HIGH 6'h12
`define USBEP_IDX_OUT_CTRL_LOW 6'h14
`define USBEP_IDX_OUT_CTRL_HIGH 6'h15
`define USBEP_IDX_OUT_CNT_LOW 6'h16
`define USBEP_IDX_OUT_CNT_HIGH 6'h17
`define USBEP_IDX_OUT_FIFO_DATA 6'h20

// ==========================================================================
// IN control high fields
`define USBEP_IN_DBL 7
`define USBEP_IN_ISO 6
`define USBEP_IN_FIFO_DIRECTION_SELECT 5
`define USBEP_IN_FTOG 3
`define USBEP_IN_SPLIT 2
`define USBEP_IN_HIGH_MASK 8'hEC

// ==========================================================================
// OUT control low fields
`define USBEP_OUT_CLRDT 7
`define USBEP_OUT_STALL_SENT_FLAG 6
`define USBEP_OUT_SEND_STALL 5
`define USBEP_OUT_FLUSH 4
`define USBEP_OUT_DATERR 3
`define USBEP_OUT_OVERRUN_FLAG 2
`define USBEP_OUT_FULL 1
`define USBEP_OUT_OUT_PACKET_READY 0

// ==========================================================================
// OUT control high fields
`define USBEP_OUT_DBL 7
`define USBEP_OUT_ISO 6

// ==========================================================================
// Reset values and codes
`define USBEP_BYTE_RESET 8'h00
`define USBEP_WORD_RESET 32'h0000_0000
`define USBEP_INMODE_NONE 2'h0
`define USBEP_INMODE_UPPER 2'h1
`define USBEP_INMODE_WHOLE 2'h2
`define USBEP_HELD_NONE 2'h0
`define USBEP_HELD_ONE 2'h1
`define USBEP_HELD_TWO 2'h2
`define USBEP_BYTE_HI 7

`endif

// >>> core/usbep_pkg.sv
// Types shared by the OUT endpoint block
package usbep_pkg;

	// ======================================================================
	// Receive sequencer states
	typedef enum logic [1:0] {
		USBEP_RX_IDLE = 2'b00,
		USBEP_RX_STORE = 2'b01,
		USBEP_RX_DROP = 2'b10
	} usbep_rx_e;

	typedef logic [7:0] usbep_byte_t;

endpackage

// >>> core/usbep_fifo_mem.sv
// Dual-port byte memory of the endpoint FIFO with registered read data
module usbep_fifo_mem
	import usbep_pkg::*;
#(
	parameter int AW = 7
) (
	// Clock
	input wire logic clk,
	// Write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire usbep_byte_t wr_data,
	// Read port
	input wire logic [AW-1:0] rd_addr,
	output usbep_byte_t rd_data
);

	usbep_byte_t mem_reg [0:(1<<AW)-1];

	// ======================================================================
	// Storage
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		rd_data <= mem_reg[rd_addr];
	end

endmodule

// >>> core/usbep_top.sv
// OUT endpoint control, IN control high register and endpoint FIFO split
// Behaviour
// [R01] OUT endpoint supports interrupt, bulk and isochronous transfers.
// [R02] Writing 1 to OUT iso-select puts the endpoint in isochronous mode.
// [R03] Bulk and interrupt OUT transfers are handled identically.
// [R04] Endpoint event on out-packet-ready set and on every STALL sent.
// [R05] Iso-select at 0 means bulk/interrupt mode.
// [R06] Bulk: token plus data packet sets out-packet-ready and raises event.
// [R07] Byte-count registers give length of the packet waiting to unload.
// [R08] Firmware unloads the packet, then writes 0 to out-packet-ready.
// [R09] While send-stall is 1, every bulk OUT request gets STALL.
// [R10] Each STALL sent sets stall-sent and raises an event.
// [R11] Firmware clears stall-sent; hardware never clears it.
// [R12] Double buffered: second packet sets out-packet-ready after release.
// [R13] That re-set of out-packet-ready raises a further event.
// [R14] Firmware should enable double buffering for iso OUT.
// [R15] Iso: each packet is stored, out-packet-ready set, event raised.
// [R16] Iso packet with no free space is discarded, overrun set, event.
// [R17] Iso CRC-error packet is still stored and flags data error.
// [R18] Firmware checks data error after unloading each iso packet.
// [R19] IN control high: bits 7,6,5,3,2 writable, others read zero.
// [R20] Force-toggle 0 flips IN toggle on ACK, 1 on every packet sent.
// [R21] Split gives IN upper half, OUT lower; else direction picks owner.
`include "usbep_defines.svh"

module usbep_top
	import usbep_pkg::*;
#(
	parameter int AW = 7,
	parameter int CNT_W = 10
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Packet engine, OUT direction
	input wire logic OUT_TOKEN,
	input wire logic RX_VALID,
	input wire usbep_byte_t RX_DATA,
	input wire logic RX_END,
	input wire logic RX_CRC_ERR,
	output logic HS_ACK,
	output logic HS_NAK,
	output logic HS_STALL,
	output logic OUT_DATA_TOGGLE,
	output logic OUT_EP_EVENT,
	// Packet engine, IN direction
	input wire logic IN_TX_DONE,
	input wire logic IN_ACK_RCVD,
	output logic IN_DATA_TOGGLE,
	output logic [1:0] IN_FIFO_MODE
);

	localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);
	localparam logic [AW:0] HALF = (AW+1)'(1 << (AW - 1));
	localparam logic [AW:0] NONE = '0;

	// ======================================================================
	// Declarations
	usbep_byte_t in_ctrl_high_reg, wdat, mem_rdata, rd_mux;
	logic send_stall_reg, stall_sent_reg, overrun_reg;
	logic out_packet_ready_reg, out_packet_ready_next, out_dbl_reg, out_iso_reg;
	logic [CNT_W-1:0] slot_len_reg [0:1];
	logic [1:0] slot_err_reg, held_reg, held_next, slot_count;
	logic wr_slot_reg, rd_slot_reg, rx_iso_reg, slot_free;
	logic [AW:0] wr_ofs_reg, rd_ofs_reg, region_size, slot_size;
	usbep_rx_e rx_state_reg;
	logic [AW-1:0] wr_addr, rd_addr;
	logic mem_wr, acc, done, wr_en, rd_done, mapped, wr_low;
	logic release_pkt, commit, stall_pulse, nak_pulse, overrun_pulse;
	logic ack_pulse, data_err;
	logic [5:0] idx;

	// ======================================================================
	// FIFO partitioning
	assign region_size = in_ctrl_high_reg[`USBEP_IN_SPLIT] ? HALF :
		(in_ctrl_high_reg[`USBEP_IN_FIFO_DIRECTION_SELECT] ? DEPTH : NONE); // R21
	assign slot_size = out_dbl_reg ? (region_size >> 1) : region_size;
	assign slot_count = (region_size == NONE) ? `USBEP_HELD_NONE :
		(out_dbl_reg ? `USBEP_HELD_TWO : `USBEP_HELD_ONE);
	assign slot_free = held_reg < slot_count;
	assign wr_addr = AW'((wr_slot_reg ? slot_size : NONE) + wr_ofs_reg);
	assign rd_addr = AW'((rd_slot_reg ? slot_size : NONE) + rd_ofs_reg);

	// ======================================================================
	// APB decode
	assign acc = PSEL & PENABLE;
	assign done = acc & PREADY;
	assign idx = PADDR[7:2];
	assign wdat = PWDATA[7:0];
	assign mapped = idx inside {`USBEP_IDX_IN_CTRL_HIGH,
		`USBEP_IDX_OUT_CTRL_LOW, `USBEP_IDX_OUT_CTRL_HIGH,
		`USBEP_IDX_OUT_CNT_LOW, `USBEP_IDX_OUT_CNT_HIGH,
		`USBEP_IDX_OUT_FIFO_DATA};
	assign wr_en = done & PWRITE & mapped;
	assign rd_done = done & ~PWRITE & mapped;
	assign wr_low = wr_en & (idx == `USBEP_IDX_OUT_CTRL_LOW);
	// Firmware releases the head packet by clearing ready or flushing
	assign release_pkt = wr_low & out_packet_ready_reg &
		(~wdat[`USBEP_OUT_OUT_PACKET_READY] | wdat[`USBEP_OUT_FLUSH]); // R08
	assign data_err = out_packet_ready_reg & out_iso_reg & slot_err_reg[rd_slot_reg];

	always_comb begin
		case (idx)
			`USBEP_IDX_IN_CTRL_HIGH: begin
				rd_mux = in_ctrl_high_reg & `USBEP_IN_HIGH_MASK; // R19
			end
			`USBEP_IDX_OUT_CTRL_LOW: begin
				rd_mux = {1'b0, stall_sent_reg, send_stall_reg, 1'b0,
					data_err, overrun_reg, held_reg == slot_count,
					out_packet_ready_reg}; // R18
			end
			`USBEP_IDX_OUT_CTRL_HIGH: begin
				rd_mux = {out_dbl_reg, out_iso_reg, 6'h00};
			end
			`USBEP_IDX_OUT_CNT_LOW: begin
				rd_mux = out_packet_ready_reg ? slot_len_reg[rd_slot_reg][7:0]
					: `USBEP_BYTE_RESET; // R07
			end
			`USBEP_IDX_OUT_CNT_HIGH: begin
				rd_mux = out_packet_ready_reg ?
					8'(slot_len_reg[rd_slot_reg][CNT_W-1:8])
					: `USBEP_BYTE_RESET; // R07
			end
			`USBEP_IDX_OUT_FIFO_DATA: rd_mux = mem_rdata;
			default: rd_mux = `USBEP_BYTE_RESET;
		endcase
	end

	// ======================================================================
	// APB answer: one wait state, data captured before completion
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			PREADY <= 1'b0;
			PRDATA <= `USBEP_WORD_RESET;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= acc & ~PREADY;
			if (acc & ~PREADY) begin
				PRDATA <= {24'h000000, rd_mux};
				PSLVERR <= ~mapped;
			end
		end
	end

	// ======================================================================
	// IN control high and IN-side outputs
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			in_ctrl_high_reg <= `USBEP_BYTE_RESET;
		end else if (wr_en && idx == `USBEP_IDX_IN_CTRL_HIGH) begin
			in_ctrl_high_reg <= wdat & `USBEP_IN_HIGH_MASK; // R19
		end
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			IN_DATA_TOGGLE <= 1'b0;
		end else if (in_ctrl_high_reg[`USBEP_IN_FTOG] ? IN_TX_DONE
				: IN_ACK_RCVD) begin
			IN_DATA_TOGGLE <= ~IN_DATA_TOGGLE; // R20
		end
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			IN_FIFO_MODE <= `USBEP_INMODE_NONE;
		end else if (in_ctrl_high_reg[`USBEP_IN_SPLIT]) begin
			IN_FIFO_MODE <= `USBEP_INMODE_UPPER; // R21
		end else if (!in_ctrl_high_reg[`USBEP_IN_FIFO_DIRECTION_SELECT]) begin
			IN_FIFO_MODE <= `USBEP_INMODE_WHOLE; // R21
		end else begin
			IN_FIFO_MODE <= `USBEP_INMODE_NONE;
		end
	end

	// ======================================================================
	// OUT control registers written by software
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			out_dbl_reg <= 1'b0;
			out_iso_reg <= 1'b0;
		end else if (wr_en && idx == `USBEP_IDX_OUT_CTRL_HIGH) begin
			out_dbl_reg <= wdat[`USBEP_OUT_DBL];
			out_iso_reg <= wdat[`USBEP_OUT_ISO]; // R02 R05
		end
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			send_stall_reg <= 1'b0;
		end else if (wr_low) begin
			send_stall_reg <= wdat[`USBEP_OUT_SEND_STALL];
		end
	end
	// Sticky flags: a hardware set wins over a software clear
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			stall_sent_reg <= 1'b0;
		end else if (stall_pulse) begin
			stall_sent_reg <= 1'b1; // R10
		end else if (wr_low && !wdat[`USBEP_OUT_STALL_SENT_FLAG]) begin
			stall_sent_reg <= 1'b0; // R11
		end
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			overrun_reg <= 1'b0;
		end else if (overrun_pulse) begin
			overrun_reg <= 1'b1; // R16
		end else if (wr_low && !wdat[`USBEP_OUT_OVERRUN_FLAG]) begin
			overrun_reg <= 1'b0;
		end
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			OUT_DATA_TOGGLE <= 1'b0;
		end else if (wr_low && wdat[`USBEP_OUT_CLRDT]) begin
			OUT_DATA_TOGGLE <= 1'b0;
		end else if (ack_pulse) begin
			OUT_DATA_TOGGLE <= ~OUT_DATA_TOGGLE;
		end
	end

	// ======================================================================
	// Receive sequencer
	always_comb begin
		stall_pulse = 1'b0;
		nak_pulse = 1'b0;
		overrun_pulse = 1'b0;
		if (OUT_TOKEN && rx_state_reg == USBEP_RX_IDLE) begin
			if (out_iso_reg) begin
				overrun_pulse = ~slot_free; // R16
			end else if (send_stall_reg) begin
				stall_pulse = 1'b1; // R09
			end else begin
				nak_pulse = ~slot_free; // R03
			end
		end
	end
	assign mem_wr = (rx_state_reg == USBEP_RX_STORE) & RX_VALID &
		(wr_ofs_reg < slot_size);
	assign commit = (rx_state_reg == USBEP_RX_STORE) & RX_END &
		(~RX_CRC_ERR | rx_iso_reg); // R15 R17
	assign ack_pulse = commit & ~rx_iso_reg; // R06
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rx_state_reg <= USBEP_RX_IDLE;
			rx_iso_reg <= 1'b0;
		end else begin
			case (rx_state_reg)
				USBEP_RX_IDLE: begin
					if (OUT_TOKEN) begin
						rx_iso_reg <= out_iso_reg; // R01
						if (stall_pulse || nak_pulse || overrun_pulse) begin
							rx_state_reg <= USBEP_RX_DROP;
						end else begin
							rx_state_reg <= USBEP_RX_STORE;
						end
					end
				end
				USBEP_RX_STORE, USBEP_RX_DROP: begin
					if (RX_END) begin
						rx_state_reg <= USBEP_RX_IDLE;
					end
				end
				default: begin
					rx_state_reg <= USBEP_RX_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wr_ofs_reg <= NONE;
		end else if (rx_state_reg != USBEP_RX_STORE || RX_END) begin
			wr_ofs_reg <= NONE;
		end else if (mem_wr) begin
			wr_ofs_reg <= wr_ofs_reg + 1'b1;
		end
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wr_slot_reg <= 1'b0;
			slot_err_reg <= 2'b00;
			slot_len_reg[0] <= '0;
			slot_len_reg[1] <= '0;
		end else if (commit) begin
			slot_len_reg[wr_slot_reg] <= CNT_W'(wr_ofs_reg);
			slot_err_reg[wr_slot_reg] <= RX_CRC_ERR & rx_iso_reg; // R17
			wr_slot_reg <= out_dbl_reg & ~wr_slot_reg;
		end
	end

	// ======================================================================
	// Packet hand-off to firmware
	always_comb begin
		held_next = held_reg;
		if (commit && !release_pkt) begin
			held_next = held_reg + 1'b1;
		end else if (release_pkt && !commit) begin
			held_next = held_reg - 1'b1;
		end
		// Ready drops for one cycle on release, then shows the next packet
		out_packet_ready_next = ~release_pkt &
			(out_packet_ready_reg | commit | (held_reg != `USBEP_HELD_NONE));
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			held_reg <= `USBEP_HELD_NONE;
			out_packet_ready_reg <= 1'b0;
		end else begin
			held_reg <= held_next; // R12
			out_packet_ready_reg <= out_packet_ready_next; // R06 R12 R15
		end
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rd_slot_reg <= 1'b0;
			rd_ofs_reg <= NONE;
		end else if (release_pkt) begin
			rd_slot_reg <= out_dbl_reg & ~rd_slot_reg;
			rd_ofs_reg <= NONE;
		end else if (rd_done && idx == `USBEP_IDX_OUT_FIFO_DATA) begin
			rd_ofs_reg <= rd_ofs_reg + 1'b1;
		end
	end

	// ======================================================================
	// Handshake and event outputs
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			HS_ACK <= 1'b0;
			HS_NAK <= 1'b0;
			HS_STALL <= 1'b0;
			OUT_EP_EVENT <= 1'b0;
		end else begin
			HS_ACK <= ack_pulse;
			HS_NAK <= nak_pulse;
			HS_STALL <= stall_pulse; // R09
			OUT_EP_EVENT <= (out_packet_ready_next & ~out_packet_ready_reg) | stall_pulse |
				overrun_pulse; // R04 R13 R16
		end
	end

	// ======================================================================
	// Endpoint FIFO storage
	usbep_fifo_mem #(
		.AW(AW)
	) u_mem (
		.clk(CLK),
		.wr_en(mem_wr),
		.wr_addr(wr_addr),
		.wr_data(RX_DATA),
		.rd_addr(rd_addr),
		.rd_data(mem_rdata)
	);

endmodule

// >>> test/usbep_host_model.sv
// Host model sending OUT tokens and data packets to the endpoint
module usbep_host_model
	import usbep_pkg::*;
(
	// Clock
	input wire logic clk,
	// Token and data toward the endpoint
	output logic out_token,
	output logic rx_valid,
	output usbep_byte_t rx_data,
	output logic rx_end,
	output logic rx_crc_err,
	// Handshakes back from the endpoint
	input wire logic hs_ack,
	input wire logic hs_nak,
	input wire logic hs_stall
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		out_token = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h5A;
		rx_end = 1'b0;
		rx_crc_err = 1'b0;
	end

	// One clock edge; handshakes seen there are collected
	task automatic step(inout logic [2:0] hs);
		@(posedge clk);
		hs = hs | {hs_ack, hs_nak, hs_stall};
	endtask

	// Token, bytes with optional idle gaps, end; collects handshakes
	task automatic pkt(input int len, input usbep_byte_t base,
		input logic crc, input int gap, output logic [2:0] hs);
		hs = 3'h0;
		@(posedge clk);
		out_token <= 1'b1;
		step(hs);
		out_token <= 1'b0;
		for (int i = 0; i < len; i++) begin
			rx_valid <= 1'b1;
			rx_data <= base + 8'(i);
			step(hs);
			if (gap > 0) begin
				rx_valid <= 1'b0;
				rx_data <= ~rx_data;
				repeat (gap) step(hs);
			end
		end
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
		rx_end <= 1'b1;
		rx_crc_err <= crc;
		step(hs);
		rx_end <= 1'b0;
		rx_crc_err <= 1'b0;
		repeat (4) step(hs);
	endtask
endmodule

// >>> test/usbep_top_chk.sv
// Concurrent checks on the ports of the OUT endpoint block
`include "usbep_defines.svh"

module usbep_top_chk (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	// Packet engine
	input wire logic OUT_TOKEN,
	input wire logic RX_END,
	input wire logic HS_ACK,
	input wire logic HS_NAK,
	input wire logic HS_STALL,
	input wire logic OUT_EP_EVENT,
	input wire logic IN_TX_DONE,
	input wire logic IN_ACK_RCVD,
	input wire logic IN_DATA_TOGGLE,
	input wire logic [1:0] IN_FIFO_MODE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	logic [7:0] sh_reg;
	logic hit;
	logic flip;
	logic [1:0] mode_exp;

	// ====================
	// Shadow of IN control high
	assign hit = PSEL && PENABLE && PREADY
		&& PADDR[7:2] == `USBEP_IDX_IN_CTRL_HIGH;
	assign flip = sh_reg[`USBEP_IN_FTOG] ? IN_TX_DONE : IN_ACK_RCVD;
	assign mode_exp = sh_reg[`USBEP_IN_SPLIT] ? `USBEP_INMODE_UPPER :
		sh_reg[`USBEP_IN_FIFO_DIRECTION_SELECT] ? `USBEP_INMODE_NONE : `USBEP_INMODE_WHOLE;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sh_reg <= `USBEP_BYTE_RESET;
		end else if (hit && PWRITE) begin
			sh_reg <= PWDATA[7:0];
		end
	end

	// ====================
	// Properties
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_wait;
		!PREADY ##1 PREADY;
	endsequence
	property p_apb;
		s_setup |=> s_wait;
	endproperty
	property p_rd;
		hit && !PWRITE |-> PRDATA == {24'h0, sh_reg & `USBEP_IN_HIGH_MASK};
	endproperty
	property p_mode;
		hit && PWRITE |-> ##2 IN_FIFO_MODE == mode_exp;
	endproperty
	property p_flip;
		flip |=> IN_DATA_TOGGLE != $past(IN_DATA_TOGGLE);
	endproperty
	property p_hold;
		!flip |=> $stable(IN_DATA_TOGGLE);
	endproperty
	property p_stl_evt;
		HS_STALL |-> ##[0:2] OUT_EP_EVENT;
	endproperty
	property p_tok;
		HS_NAK || HS_STALL |-> $past(OUT_TOKEN);
	endproperty
	property p_ack;
		HS_ACK |-> $past(RX_END) && !HS_NAK && !HS_STALL;
	endproperty

	a_apb: assert property (p_apb)
		else $error("APB answer not after one wait");
	a_rd: assert property (p_rd)
		else $error("IN control high readback wrong");
	a_mode: assert property (p_mode)
		else $error("FIFO ownership wrong");
	a_flip: assert property (p_flip)
		else $error("IN toggle did not flip");
	a_hold: assert property (p_hold)
		else $error("IN toggle flipped without cause");
	a_stl_evt: assert property (p_stl_evt)
		else $error("STALL without endpoint event");
	a_tok: assert property (p_tok)
		else $error("Token handshake without token");
	a_ack: assert property (p_ack)
		else $error("ACK without packet end");
endmodule

bind usbep_top usbep_top_chk u_chk (.CLK, .RST, .PSEL, .PENABLE, .PWRITE,
	.PADDR, .PWDATA, .PRDATA, .PREADY, .OUT_TOKEN, .RX_END, .HS_ACK,
	.HS_NAK, .HS_STALL, .OUT_EP_EVENT, .IN_TX_DONE, .IN_ACK_RCVD,
	.IN_DATA_TOGGLE, .IN_FIFO_MODE);

// >>> test/usbep_top_tb.sv
// Testbench of the OUT endpoint block
`include "usbep_defines.svh"

module usbep_top_tb import usbep_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [5:0] IH = `USBEP_IDX_IN_CTRL_HIGH;
	localparam logic [5:0] OL = `USBEP_IDX_OUT_CTRL_LOW;
	localparam logic [5:0] OH = `USBEP_IDX_OUT_CTRL_HIGH;
	localparam logic [2:0] ACK = 3'h4;
	localparam logic [2:0] NAK = 3'h2;
	localparam logic [2:0] STL = 3'h1;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic in_tx_done = 1'b0;
	logic in_ack_rcvd = 1'b0;
	logic [31:0] prdata;
	logic [31:0] r;
	logic pready, pslverr, out_token, rx_valid, rx_end, rx_crc_err;
	logic hs_ack, hs_nak, hs_stall, evt, in_tog, e, out_tog;
	logic [1:0] in_mode;
	logic [2:0] hs;
	usbep_byte_t rx_data;
	int fail_count = 0;
	int checked = 0;
	int evt_count = 0;
	int cyc = 0;

	always #4 clk = ~clk;

	usbep_top u_dut (.CLK(clk), .RST(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .OUT_TOKEN(out_token), .RX_VALID(rx_valid),
		.RX_DATA(rx_data), .RX_END(rx_end), .RX_CRC_ERR(rx_crc_err),
		.HS_ACK(hs_ack), .HS_NAK(hs_nak), .HS_STALL(hs_stall),
		.OUT_DATA_TOGGLE(out_tog), .OUT_EP_EVENT(evt),
		.IN_TX_DONE(in_tx_done),
		.IN_ACK_RCVD(in_ack_rcvd), .IN_DATA_TOGGLE(in_tog),
		.IN_FIFO_MODE(in_mode));

	usbep_host_model u_host (.clk, .out_token, .rx_valid, .rx_data,
		.rx_end, .rx_crc_err, .hs_ack, .hs_nak, .hs_stall);

	// ====================
	// Cycle ceiling and event counter
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (evt === 1'b1) begin
			evt_count <= evt_count + 1;
		end
		if (cyc == 8000) begin
			fail_count++;
			give_verdict();
		end
	end

	task give_verdict();
		if (fail_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// ====================
	// APB master and firmware helpers
	task apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [5:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask

	task rdc(input logic [5:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(r, {24'h0, exp});
	endtask

	task pk(input int len, input logic [7:0] base, input logic crc,
		input int gap, input logic [2:0] exp);
		u_host.pkt(len, base, crc, gap, hs);
		chk({29'h0, hs}, {29'h0, exp});
	endtask

	task drain(input int len, input logic [7:0] base);
		rdc(`USBEP_IDX_OUT_CNT_LOW, 8'(len));
		rdc(`USBEP_IDX_OUT_CNT_HIGH, 8'h00);
		for (int i = 0; i < len; i++) begin
			rdc(`USBEP_IDX_OUT_FIFO_DATA, base + 8'(i));
		end
		wr(OL, 8'h00);
	endtask

	task tg(input logic t, input logic a, input logic exp);
		@(posedge clk);
		in_tx_done <= t;
		in_ack_rcvd <= a;
		@(posedge clk);
		in_tx_done <= 1'b0;
		in_ack_rcvd <= 1'b0;
		@(posedge clk);
		chk({31'h0, in_tog}, {31'h0, exp});
	endtask

	// ====================
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdc(IH, 8'h00);
		wr(IH, 8'hFF);
		rdc(IH, 8'hEC);
		apb(1'b0, 6'h3F, 8'h00);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		wr(IH, 8'h00);
		pk(2, 8'h10, 1'b0, 0, NAK);
		chk({30'h0, in_mode}, 32'h2);
		wr(IH, 8'h24);
		tg(1'b1, 1'b0, 1'b0);
		tg(1'b0, 1'b1, 1'b1);
		wr(IH, 8'h2C);
		tg(1'b1, 1'b0, 1'b0);
		tg(1'b0, 1'b1, 1'b0);
		chk({30'h0, in_mode}, 32'h1);
		wr(IH, 8'h20);
		pk(3, 8'hA0, 1'b0, 2, ACK);
		chk({31'h0, out_tog}, 32'h1);
		chk({30'h0, in_mode}, 32'h0);
		rdc(OL, 8'h03);
		chk(evt_count, 1);
		drain(3, 8'hA0);
		rdc(OL, 8'h00);
		pk(2, 8'h30, 1'b1, 0, 3'h0);
		rdc(OL, 8'h00);
		wr(OL, 8'h20);
		pk(2, 8'h40, 1'b0, 0, STL);
		rdc(OL, 8'h60);
		chk(evt_count, 2);
		pk(1, 8'h41, 1'b0, 1, STL);
		wr(OL, 8'h60);
		rdc(OL, 8'h60);
		chk(evt_count, 3);
		wr(OL, 8'h00);
		rdc(OL, 8'h00);
		wr(OH, 8'h80);
		pk(2, 8'h50, 1'b0, 0, ACK);
		pk(4, 8'h60, 1'b0, 0, ACK);
		pk(1, 8'h70, 1'b0, 0, NAK);
		rdc(OL, 8'h03);
		drain(2, 8'h50);
		rdc(OL, 8'h01);
		chk(evt_count, 5);
		drain(4, 8'h60);
		wr(OH, 8'hC0);
		pk(2, 8'h80, 1'b1, 0, 3'h0);
		pk(3, 8'h90, 1'b0, 1, 3'h0);
		pk(1, 8'hA0, 1'b0, 0, 3'h0);
		rdc(OL, 8'h0F);
		chk(evt_count, 7);
		drain(2, 8'h80);
		rdc(OL, 8'h01);
		chk(evt_count, 8);
		drain(3, 8'h90);
		wr(OH, 8'h00);
		pk(1, 8'hB0, 1'b0, 0, ACK);
		chk({31'h0, out_tog}, 32'h0);
		drain(1, 8'hB0);
		chk(evt_count, 9);
		give_verdict();
	end
endmodule
